/* File: include/pllc_map.svh */
// pllc_map.svh: register offsets, field positions, reset values and timing counts
// for the clock generator controller; included by bare name, definitions only.
`ifndef PLLC_MAP_SVH
`define PLLC_MAP_SVH

// byte addresses of the controller registers
`define PLLC_CSR_OFS      32'h01B7C100
`define PLLC_MULT_OFS     32'h01B7C110
`define PLLC_DIV0_OFS     32'h01B7C114
`define PLLC_DIV1_OFS     32'h01B7C118
`define PLLC_DIV2_OFS     32'h01B7C11C
`define PLLC_DIV3_OFS     32'h01B7C120
`define PLLC_OSC_OFS      32'h01B7C124

// control/status field positions and the divider enable bit
`define PLLC_CSR_EN_BIT   0
`define PLLC_CSR_PWD_BIT  1
`define PLLC_CSR_RSV_BIT  2
`define PLLC_CSR_RST_BIT  3
`define PLLC_CSR_STB_BIT  6
`define PLLC_DIV_EN_BIT   15

// reset values
`define PLLC_MULT_RST     5'h07
`define PLLC_DIV0_RST     5'h00
`define PLLC_DIV1_RST     5'h00
`define PLLC_DIV2_RST     5'h01
`define PLLC_DIV3_RST     5'h01
`define PLLC_OSC_RST      5'h07

// timing: clock period, pll reset and lock times
`define PLLC_CLK_PERIOD_NS 100
`define PLLC_RESET_TIME_NS 125
`define PLLC_LOCK_TIME_NS  187500
`define PLLC_RESET_CYC  ((`PLLC_RESET_TIME_NS + `PLLC_CLK_PERIOD_NS - 1) / `PLLC_CLK_PERIOD_NS)
`define PLLC_LOCK_CYC   (`PLLC_LOCK_TIME_NS / `PLLC_CLK_PERIOD_NS)
`define PLLC_STABLE_CYC 256

`endif

/* File: include/pllc_pkg.sv */
// pllc_pkg: types shared by the clock generator controller files.
// assumes nothing of its surroundings.
package pllc_pkg;
    typedef logic [4:0] pllc_ratio_t;
    typedef enum logic {PLLC_ST_COUNT, PLLC_ST_STABLE} pllc_stab_e;
endpackage : pllc_pkg

/* File: src/pllc_div.sv */
// pllc_div: one programmable divider, ratio field value + 1, counting source ticks.
// assumes tick_i is a one-cycle pulse per source clock period.
`timescale 1ns/1ps
module pllc_div (
    input  wire logic                  mclk_i,
    input  wire logic                  rst_b_i,
    input  wire logic                  tick_i,
    input  wire logic                  en_i,
    input  wire pllc_pkg::pllc_ratio_t ratio_i,
    output logic                       tick_o,
    output logic                       clk_o
);
    import pllc_pkg::*;

    pllc_ratio_t count;
    pllc_ratio_t next_count;
    logic        next_tick;
    logic        next_clk;
    logic [5:0]  half;

    always_comb begin
        half       = (6'({1'b0, ratio_i}) + 6'h02) >> 1;
        next_count = count;
        next_tick  = 1'b0;
        next_clk   = clk_o;
        if (!en_i) begin
            next_count = 5'h00;
            next_clk   = 1'b0;
        end else if (tick_i) begin
            if (count >= ratio_i) begin
                next_count = 5'h00;
                next_tick  = 1'b1;
            end else begin
                next_count = count + 5'h01;
            end
            // high for the first half of each output period
            next_clk = ({1'b0, next_count} < half);
        end else if (ratio_i == 5'h00) begin
            // divide by one: high only after each tick, so one rise per tick;
            // ticks on every cycle leave the output high
            next_clk = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            count  <= 5'h00;
            tick_o <= 1'b0;
            clk_o  <= 1'b0;
        end else begin
            count  <= next_count;
            tick_o <= next_tick;
            clk_o  <= next_clk;
        end
    end
endmodule : pllc_div

/* File: src/pllc_top.sv */
// pllc_top: clock generator controller, registers, dividers and clock selection.
// assumes all pins synchronous to mclk_i; the analog pll is outside and returns
// one pulse per output period on pll_tick_i.
// Function
// - raw input clock goes undivided to the audio ports as aux clock
// - oscillator divider 1..32 divides input clock onto third clock output
// - prescaler 1..32 then pll multiplier x4..x25; the code passes any field value 0..31 to pll_mult_o
// - reference is input clock when mode enable 0, pll output when 1
// - core, bus and memory clocks each have their own divider
// - memory interface clock from its input pin or third system clock
// - bus clock drives the second clock output directly
// - bit 6 reads 0 while stabilization counts, 1 once stable
// - bit 3 holds pll in reset, set after reset, cleared releases
// - bit 1 set powers pll down, clear keeps it running
// - bit 0 clear bypasses prescaler and pll, set uses pll output
// - reserved bits 31:7 and 5:4 read zero, writes ignored
`timescale 1ns/1ps
`include "pllc_map.svh"
module pllc_top #(
    parameter int STABLE_CYC = `PLLC_STABLE_CYC
) (
    input  wire logic          mclk_i,
    input  wire logic          rst_b_i,
    input  wire logic [31:0]   reg_addr_i,
    input  wire logic          reg_wr_i,
    input  wire logic          reg_rd_i,
    input  wire logic [31:0]   reg_wdata_i,
    output logic      [31:0]   reg_rdata_o,
    input  wire logic          input_ref_clock_i,
    input  wire logic          pll_tick_i,
    input  wire logic          ext_mem_clock_input_i,
    input  wire logic          ext_mem_clock_source_sel_i,
    output logic               audio_aux_clock_o,
    output logic               third_clock_output_o,
    output logic               pll_reference_o,
    output pllc_pkg::pllc_ratio_t pll_mult_o,
    output logic               pll_reset_ctrl_o,
    output logic               pll_power_down_o,
    output logic               core_clock_o,
    output logic               periph_bus_clock_o,
    output logic               second_clock_output_o,
    output logic               ext_mem_clock_o,
    output logic               external_memory_interface_clock_o
);
    import pllc_pkg::*;

    logic        pll_mode_enable, next_pll_mode_enable;
    logic        rsv_bit, next_rsv_bit;
    logic        next_pll_reset_ctrl, next_pll_power_down;
    pllc_ratio_t next_pll_mult;
    pllc_ratio_t ratio [5];
    pllc_ratio_t next_ratio [5];
    logic [4:0]  div_en, next_div_en;
    logic [31:0] next_rdata;
    logic        ref_q, ref_tick, sel_tick, next_aux;
    pllc_stab_e  stab_state, next_stab_state;
    logic [15:0] stab_cnt, next_stab_cnt;
    logic        next_external_memory_interface;
    logic        wr_csr;

    // index 0 prescaler, 1 core, 2 bus, 3 memory, 4 oscillator
    localparam logic [31:0] DIV_OFS [5] = '{`PLLC_DIV0_OFS, `PLLC_DIV1_OFS,
        `PLLC_DIV2_OFS, `PLLC_DIV3_OFS, `PLLC_OSC_OFS};
    localparam pllc_ratio_t DIV_RST [5] = '{`PLLC_DIV0_RST, `PLLC_DIV1_RST,
        `PLLC_DIV2_RST, `PLLC_DIV3_RST, `PLLC_OSC_RST};

    assign ref_tick = input_ref_clock_i & ~ref_q;
    assign sel_tick = pll_mode_enable ? pll_tick_i : ref_tick;
    assign wr_csr   = reg_wr_i && (reg_addr_i == `PLLC_CSR_OFS);

    // register writes and read data
    always_comb begin
        next_pll_mode_enable = pll_mode_enable;
        next_rsv_bit         = rsv_bit;
        next_pll_reset_ctrl  = pll_reset_ctrl_o;
        next_pll_power_down  = pll_power_down_o;
        next_pll_mult        = pll_mult_o;
        next_ratio           = ratio;
        next_div_en          = div_en;
        next_rdata           = 32'h00000000;
        if (wr_csr) begin
            next_pll_mode_enable = reg_wdata_i[`PLLC_CSR_EN_BIT];
            next_pll_power_down  = reg_wdata_i[`PLLC_CSR_PWD_BIT];
            next_rsv_bit         = reg_wdata_i[`PLLC_CSR_RSV_BIT];
            next_pll_reset_ctrl  = reg_wdata_i[`PLLC_CSR_RST_BIT];
        end
        if (reg_wr_i && reg_addr_i == `PLLC_MULT_OFS) begin
            next_pll_mult = reg_wdata_i[4:0];
        end
        for (int i = 0; i < 5; i++) begin
            if (reg_wr_i && reg_addr_i == DIV_OFS[i]) begin
                next_ratio[i]  = reg_wdata_i[4:0];
                next_div_en[i] = reg_wdata_i[`PLLC_DIV_EN_BIT];
            end
        end
        if (reg_rd_i) begin
            if (reg_addr_i == `PLLC_CSR_OFS) begin
                // unlisted bits stay zero
                next_rdata[`PLLC_CSR_EN_BIT]  = pll_mode_enable;
                next_rdata[`PLLC_CSR_PWD_BIT] = pll_power_down_o;
                next_rdata[`PLLC_CSR_RSV_BIT] = rsv_bit;
                next_rdata[`PLLC_CSR_RST_BIT] = pll_reset_ctrl_o;
                next_rdata[`PLLC_CSR_STB_BIT] = (stab_state == PLLC_ST_STABLE);
            end
            if (reg_addr_i == `PLLC_MULT_OFS) begin
                next_rdata[4:0] = pll_mult_o;
            end
            for (int i = 0; i < 5; i++) begin
                if (reg_addr_i == DIV_OFS[i]) begin
                    next_rdata[4:0]             = ratio[i];
                    next_rdata[`PLLC_DIV_EN_BIT] = div_en[i];
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pll_mode_enable  <= 1'b0;
            rsv_bit          <= 1'b0;
            pll_reset_ctrl_o <= 1'b1;
            pll_power_down_o <= 1'b0;
            pll_mult_o       <= `PLLC_MULT_RST;
            ratio            <= DIV_RST;
            div_en           <= 5'h1F;
            reg_rdata_o      <= 32'h00000000;
        end else begin
            pll_mode_enable  <= next_pll_mode_enable;
            rsv_bit          <= next_rsv_bit;
            pll_reset_ctrl_o <= next_pll_reset_ctrl;
            pll_power_down_o <= next_pll_power_down;
            pll_mult_o       <= next_pll_mult;
            ratio            <= next_ratio;
            div_en           <= next_div_en;
            reg_rdata_o      <= next_rdata;
        end
    end

    // input clock stabilization counter
    always_comb begin
        next_stab_state = stab_state;
        next_stab_cnt   = stab_cnt;
        case (stab_state)
            PLLC_ST_COUNT: begin
                if (ref_tick) begin
                    if (stab_cnt >= 16'(STABLE_CYC - 1)) begin
                        next_stab_state = PLLC_ST_STABLE;
                    end else begin
                        next_stab_cnt = stab_cnt + 16'h0001;
                    end
                end
            end
            PLLC_ST_STABLE: next_stab_state = PLLC_ST_STABLE;
            default:        next_stab_state = PLLC_ST_COUNT;
        endcase
    end

    always_comb begin
        next_aux  = input_ref_clock_i;
        next_external_memory_interface = ext_mem_clock_source_sel_i ? ext_mem_clock_input_i
                                               : ext_mem_clock_o;
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            stab_state        <= PLLC_ST_COUNT;
            stab_cnt          <= 16'h0000;
            ref_q             <= 1'b0;
            audio_aux_clock_o <= 1'b0;
            external_memory_interface_clock_o      <= 1'b0;
        end else begin
            stab_state        <= next_stab_state;
            stab_cnt          <= next_stab_cnt;
            ref_q             <= input_ref_clock_i;
            audio_aux_clock_o <= next_aux;
            external_memory_interface_clock_o      <= next_external_memory_interface;
        end
    end

    // prescaler feeds the pll reference
    pllc_div u_pre (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tick_i(ref_tick),
        .en_i(div_en[0]), .ratio_i(ratio[0]), .tick_o(), .clk_o(pll_reference_o));
    // post dividers off the selected reference, oscillator divider off the input clock
    pllc_div u_core (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tick_i(sel_tick),
        .en_i(div_en[1]), .ratio_i(ratio[1]), .tick_o(), .clk_o(core_clock_o));
    pllc_div u_bus (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tick_i(sel_tick),
        .en_i(div_en[2]), .ratio_i(ratio[2]), .tick_o(), .clk_o(periph_bus_clock_o));
    pllc_div u_mem (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tick_i(sel_tick),
        .en_i(div_en[3]), .ratio_i(ratio[3]), .tick_o(), .clk_o(ext_mem_clock_o));
    pllc_div u_osc (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .tick_i(ref_tick),
        .en_i(div_en[4]), .ratio_i(ratio[4]), .tick_o(), .clk_o(third_clock_output_o));

    assign second_clock_output_o = periph_bus_clock_o;

    chk_aux_follow: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ##1 audio_aux_clock_o == $past(input_ref_clock_i))
        else $error("aux clock does not follow input clock");
    chk_bypass_src: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (!pll_mode_enable && ref_tick) |-> sel_tick)
        else $error("bypass does not use input clock");
    chk_pll_src: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (pll_mode_enable && !pll_tick_i) |-> !sel_tick)
        else $error("pll mode takes input clock ticks");
    chk_reset_release: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (wr_csr && !reg_wdata_i[`PLLC_CSR_RST_BIT]) |=> !pll_reset_ctrl_o
        ##1 (!pll_reset_ctrl_o || $past(wr_csr)))
        else $error("pll reset not released");
    chk_reset_hold: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (pll_reset_ctrl_o && !wr_csr) |=> pll_reset_ctrl_o)
        else $error("pll reset dropped without write");
    chk_power_down: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (wr_csr && reg_wdata_i[`PLLC_CSR_PWD_BIT]) |=> pll_power_down_o)
        else $error("pll not powered down");
    chk_csr_reserved: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `PLLC_CSR_OFS) |=>
        (reg_rdata_o[31:7] == 25'h0 && reg_rdata_o[5:4] == 2'h0))
        else $error("reserved bits read nonzero");
    chk_stable_flag: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (reg_rd_i && reg_addr_i == `PLLC_CSR_OFS && stab_cnt == 16'h0000 && !ref_tick)
        |=> !reg_rdata_o[`PLLC_CSR_STB_BIT])
        else $error("stable set before counting");
    chk_external_memory_interface_pin: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        ext_mem_clock_source_sel_i |=> external_memory_interface_clock_o == $past(ext_mem_clock_input_i))
        else $error("memory clock pin not selected");
    chk_mult_load: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
        (reg_wr_i && reg_addr_i == `PLLC_MULT_OFS) |=> pll_mult_o == $past(reg_wdata_i[4:0]))
        else $error("multiplier not loaded");
endmodule : pllc_top

/* File: tb/testbench.sv */
// testbench: self-checking bench for the clock generator controller top.
// assumes a 10 MHz mclk_i; the bench plays software, the input clock and the analog pll.
`timescale 1ns/1ps
`include "pllc_map.svh"
module testbench;
    import pllc_pkg::*;
    localparam int STABLE = 4;
    localparam logic [31:0] ADDRS [8] = '{`PLLC_CSR_OFS, `PLLC_MULT_OFS, `PLLC_DIV0_OFS,
        `PLLC_DIV1_OFS, `PLLC_DIV2_OFS, `PLLC_DIV3_OFS, `PLLC_OSC_OFS, 32'h01B7C104};
    localparam logic [31:0] RESETS [8] = '{32'h00000008, 32'h00000007, 32'h00008000,
        32'h00008000, 32'h00008001, 32'h00008001, 32'h00008007, 32'h00000000};
    logic        mclk_i, rst_b_i, reg_wr, reg_rd, in_clk, pll_tick, ext_pin, ext_sel;
    logic [31:0] reg_addr, reg_wdata, reg_rdata, d;
    pllc_ratio_t pll_mult;
    logic        aux, third, pll_ref, pll_rst, pll_pwd, core, bus, clk2, mem, external_memory_interface;
    logic [6:0]  sig, sig_q;
    int          rises [7];
    bit          counting;
    int          aux_bad, errors, num_checks, cycles;

    pllc_top #(.STABLE_CYC(STABLE)) u_pllc_top (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .reg_addr_i(reg_addr), .reg_wr_i(reg_wr),
        .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata),
        .input_ref_clock_i(in_clk), .pll_tick_i(pll_tick), .ext_mem_clock_input_i(ext_pin),
        .ext_mem_clock_source_sel_i(ext_sel), .audio_aux_clock_o(aux),
        .third_clock_output_o(third), .pll_reference_o(pll_ref), .pll_mult_o(pll_mult),
        .pll_reset_ctrl_o(pll_rst), .pll_power_down_o(pll_pwd), .core_clock_o(core),
        .periph_bus_clock_o(bus), .second_clock_output_o(clk2), .ext_mem_clock_o(mem),
        .external_memory_interface_clock_o(external_memory_interface));

    assign sig = {external_memory_interface, clk2, mem, bus, core, pll_ref, third};

    initial begin
        mclk_i = 1'b0;
        forever #50 mclk_i = ~mclk_i;
    end

    // rising edges of every derived clock except the aux copy inside the counting window
    always @(posedge mclk_i) begin
        sig_q <= sig;
        cycles++;
        if (counting)
            for (int i = 0; i < 7; i++)
                if (sig[i] && !sig_q[i]) rises[i]++;
        if (cycles == 6000) begin
            errors++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // the bench writes as the processor would, never through a host port
    task automatic wr(input logic [31:0] a, input logic [31:0] v);
        @(negedge mclk_i);
        reg_addr = a;
        reg_wdata = v;
        reg_wr = 1'b1;
        @(negedge mclk_i);
        reg_wr = 1'b0;
        @(negedge mclk_i);
    endtask : wr

    task automatic rd(input logic [31:0] a, output logic [31:0] v);
        @(negedge mclk_i);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk_i);
        reg_rd = 1'b0;
        v = reg_rdata;
    endtask : rd

    // one input clock period of four mclk cycles, two pll ticks, two pin rises;
    // rates stay well inside the reference, pll and aux clock limits
    task automatic period();
        for (int c = 0; c < 4; c++) begin
            @(negedge mclk_i);
            if (aux !== in_clk) aux_bad++;
            in_clk = (c < 2);
            pll_tick = (c % 2 == 0);
            ext_pin = ~ext_pin;
        end
    endtask : period

    task automatic run_check(input int n, input int exp [7], input string what);
        repeat (8) period();
        for (int i = 0; i < 7; i++) rises[i] = 0;
        counting = 1'b1;
        repeat (n) period();
        counting = 1'b0;
        for (int i = 0; i < 7; i++) check(32'(rises[i]), 32'(exp[i]), what);
    endtask : run_check

    task automatic t_reset();
        for (int i = 0; i < 8; i++) begin
            rd(ADDRS[i], d);
            check(d, RESETS[i], "reset value");
        end
        check({31'h0, pll_rst}, 32'h1, "pll reset after reset");
        check({31'h0, pll_pwd}, 32'h0, "power down after reset");
        check({27'h0, pll_mult}, 32'h7, "multiplier after reset");
        $display("t_reset done");
    endtask : t_reset

    task automatic t_csr();
        wr(`PLLC_CSR_OFS, 32'hFFFFFFFA);
        rd(`PLLC_CSR_OFS, d);
        check(d, 32'h0000000A, "csr reserved bits");
        check({31'h0, pll_pwd}, 32'h1, "power down set");
        check({31'h0, pll_rst}, 32'h1, "pll reset held");
        wr(`PLLC_CSR_OFS, 32'h00000008);
        check({31'h0, pll_pwd}, 32'h0, "power down clear");
        $display("t_csr done");
    endtask : t_csr

    task automatic t_regs();
        wr(`PLLC_MULT_OFS, 32'hFFFFFFF9);
        rd(`PLLC_MULT_OFS, d);
        check(d, 32'h00000019, "multiplier read");
        check({27'h0, pll_mult}, 32'h19, "multiplier out");
        wr(`PLLC_DIV0_OFS, 32'hFFFF8001);
        rd(`PLLC_DIV0_OFS, d);
        check(d, 32'h00008001, "prescaler read");
        $display("t_regs done");
    endtask : t_regs

    task automatic t_bypass();
        wr(`PLLC_DIV2_OFS, 32'h00008003);
        wr(`PLLC_DIV1_OFS, 32'h00008001);
        wr(`PLLC_DIV3_OFS, 32'h00008002);
        wr(`PLLC_OSC_OFS, 32'h00008003);
        run_check(24, '{6, 12, 12, 6, 8, 6, 8}, "bypass clock rates");
        $display("t_bypass done");
    endtask : t_bypass

    task automatic t_pll();
        wr(`PLLC_CSR_OFS, 32'h00000000);
        check({31'h0, pll_rst}, 32'h0, "pll reset released");
        repeat (`PLLC_LOCK_CYC) @(negedge mclk_i);
        wr(`PLLC_CSR_OFS, 32'h00000001);
        ext_sel = 1'b1;
        run_check(24, '{6, 12, 24, 12, 16, 12, 48}, "pll clock rates");
        rd(`PLLC_CSR_OFS, d);
        check(d, 32'h00000041, "stable after input edges");
        $display("t_pll done");
    endtask : t_pll

    task automatic t_disable();
        wr(`PLLC_OSC_OFS, 32'h00000003);
        wr(`PLLC_DIV1_OFS, 32'h00008000);
        wr(`PLLC_DIV2_OFS, 32'h00008001);
        run_check(24, '{0, 12, 48, 24, 16, 24, 48}, "osc off, core /1");
        check({31'h0, third}, 32'h0, "third output low");
        $display("t_disable done");
    endtask : t_disable

    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    initial begin
        rst_b_i = 1'b0;
        {reg_wr, reg_rd, in_clk, pll_tick, ext_pin, ext_sel} = 6'h00;
        reg_addr = 32'h00000000;
        reg_wdata = 32'h00000000;
        repeat (6) @(negedge mclk_i);
        rst_b_i = 1'b1;
        t_reset();
        t_csr();
        t_regs();
        t_bypass();
        t_pll();
        t_disable();
        check(32'(aux_bad), 32'h0, "aux clock copy");
        give_verdict();
    end
endmodule : testbench
